// [hdl/shs_pkg.sv]
// shared constants of the host status register bank
// assumes byte offsets on a 16-bit map, 32-bit data words
package shs_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int WORD_W  = 32;
    localparam int BADDR_W = 16;
    localparam int WADDR_W = 14;
    localparam int BYTE_SH = 2;

    // ------------------------------------------------------------
    // area selectors, upper byte-address bits
    // ------------------------------------------------------------
    localparam logic [3:0] AREA_CORE     = 4'h4;
    localparam logic [3:0] AREA_GEN_LO   = 4'h5;
    localparam logic [3:0] AREA_GEN_HI   = 4'h7;
    localparam logic [1:0] SEL_NONE      = 2'h0;
    localparam logic [1:0] SEL_CORE      = 2'h1;
    localparam logic [1:0] SEL_GEN       = 2'h2;
    localparam logic [1:0] SEL_VER       = 2'h3;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [15:0] OFF_HOST_STATUS   = 16'h0400;
    localparam logic [15:0] OFF_DISK_LOW      = 16'h0410;
    localparam logic [15:0] OFF_DISK_HIGH     = 16'h0414;
    localparam logic [15:0] OFF_CAP_LOW       = 16'h0420;
    localparam logic [15:0] OFF_CAP_HIGH      = 16'h0424;
    localparam logic [15:0] OFF_ERROR_TYPE    = 16'h0430;
    localparam logic [15:0] OFF_COMPLETION    = 16'h0440;
    localparam logic [15:0] OFF_DEBUG_W0      = 16'h0450;
    localparam logic [15:0] OFF_DEBUG_W1      = 16'h0454;
    localparam logic [15:0] OFF_DEBUG_W2      = 16'h0458;
    localparam logic [15:0] OFF_DEBUG_W3      = 16'h045C;
    localparam logic [15:0] OFF_EXPECT_W0     = 16'h0500;
    localparam logic [15:0] OFF_EXPECT_W1     = 16'h0504;
    localparam logic [15:0] OFF_EXPECT_W2     = 16'h0508;
    localparam logic [15:0] OFF_EXPECT_W3     = 16'h050C;
    localparam logic [15:0] OFF_READ_W0       = 16'h0540;
    localparam logic [15:0] OFF_READ_W1       = 16'h0544;
    localparam logic [15:0] OFF_READ_W2       = 16'h0548;
    localparam logic [15:0] OFF_READ_W3       = 16'h054C;
    localparam logic [15:0] OFF_FAIL_LOW      = 16'h0580;
    localparam logic [15:0] OFF_FAIL_HIGH     = 16'h0584;
    localparam logic [15:0] OFF_PROGRESS_LOW  = 16'h0590;
    localparam logic [15:0] OFF_PROGRESS_HIGH = 16'h0594;
    localparam logic [15:0] OFF_VERSION       = 16'h0800;

    // ------------------------------------------------------------
    // host status bit positions
    // ------------------------------------------------------------
    localparam int HS_LINK_UP   = 0;
    localparam int HS_CONNECTED = 1;
    localparam int HS_CORE_BUSY = 2;
    localparam int HS_CORE_ERR  = 3;
    localparam int HS_GEN_BUSY  = 4;
    localparam int HS_GEN_FAIL  = 5;
    localparam int HS_W         = 6;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;
    localparam logic [5:0]  RST_HOST_STAT  = 6'h00;
    localparam logic [63:0] RST_PROGRESS   = 64'h0;
    localparam logic [63:0] BYTES_PER_WORD = 64'h10;
    localparam int          RD_LATENCY     = 2;

endpackage

// [hdl/shs_capture.sv]
// first-event capture register with its own sticky flag
// assumes clear and hit come from logic on the same clock
`timescale 1ns/1ns
module shs_capture
    import shs_pkg::*;
#(
    parameter int W = 128
) (
    input  wire logic         CLK,
    input  wire logic         SYS_RST,
    input  wire logic         CLEAR,
    input  wire logic         HIT,
    input  wire logic [W-1:0] DATA,
    output logic      [W-1:0] HELD,
    output logic              TAKEN
);

    // ------------------------------------------------------------
    // capture
    // ------------------------------------------------------------
    // a hit in the clear cycle still counts: it opens the new test
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            HELD  <= '0;
            TAKEN <= 1'b0;
        end else if (HIT && (CLEAR || !TAKEN)) begin
            HELD  <= DATA;
            TAKEN <= 1'b1;
        end else if (CLEAR) begin
            TAKEN <= 1'b0;
        end
    end

endmodule

// [hdl/shs_status_regs.sv]
// read-only status register bank of the storage host test system
// assumes all status inputs run on CLK; requester holds the address
`timescale 1ns/1ns

// Function
// - host status bit 0 shows ethernet link up
// - host status bit 1 shows connection established
// - host status bit 2 shows host core busy
// - host status bit 3 shows host core error found
// - host status bit 4 shows pattern generator test running
// - host status bit 5 shows read verification mismatch seen
// - 48-bit disk size split over 0x0410 and low half of 0x0414
// - 48-bit capability split over 0x0420 and 0x0424
// - 0x0430 returns the 32-bit error type vector unchanged
// - 0x0440 holds admin status low, i/o status high
// - 128-bit debug pins as four words from 0x0450, low first
// - expected data of first failing word at 0x0500-0x050C
// - read data of first failing word at 0x0540-0x054C
// - 57-bit first failure byte address at 0x0580 and 0x0584
// - 57-bit error-free byte count at 0x0590 and 0x0594
// - 0x0800 returns the host core version word
// - status area is read-only; writes never change status
// - read data and valid two cycles after request
module shs_status_regs
    import shs_pkg::*;
#(
    parameter int CAPACITY_W = 48,
    parameter int FAIL_ADDR_W = 57,
    parameter int PROGRESS_W = 57
) (
    input  wire logic          CLK,
    input  wire logic          SYS_RST,
    input  wire logic [13:0]   REG_ADDR,
    input  wire logic          REG_RD_REQ,
    output logic      [31:0]   REG_RD_DATA,
    output logic               REG_RD_VALID,
    input  wire logic          LINK_UP,
    input  wire logic          CONNECTION_STATE,
    input  wire logic          CORE_ACTIVE,
    input  wire logic          CORE_FAULT,
    input  wire logic [31:0]   FAULT_VECTOR,
    input  wire logic [47:0]   TARGET_CAPACITY,
    input  wire logic [47:0]   TARGET_CAPABILITY,
    input  wire logic [15:0]   ADMIN_COMPLETION,
    input  wire logic [15:0]   IO_COMPLETION,
    input  wire logic [127:0]  DEBUG_PINS,
    input  wire logic [31:0]   CORE_VERSION,
    input  wire logic          GENERATOR_ACTIVE,
    input  wire logic          TEST_START,
    input  wire logic          VERIFY_VALID,
    input  wire logic [127:0]  VERIFY_EXPECT,
    input  wire logic [127:0]  VERIFY_READ,
    input  wire logic [56:0]   VERIFY_ADDR,
    output logic               VERIFY_FAULT
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (CAPACITY_W != 48) begin : g_bad_cap
        $error("capacity width must be 48");
    end
    if (FAIL_ADDR_W <= 32 || FAIL_ADDR_W > 57) begin : g_bad_fail
        $error("failure address width must be 33 to 57");
    end
    if (PROGRESS_W <= 32 || PROGRESS_W > 64) begin : g_bad_prog
        $error("progress width must be 33 to 64");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:0]            byte_addr;
    logic [3:0]             area_bits;
    logic [5:0]             host_status_reg;
    logic [5:0]             host_status_next;
    logic [127:0]           expected_words;
    logic [127:0]           readback_words;
    logic [56:0]            fail_address;
    logic                   fail_taken;
    logic                   mismatch;
    logic                   good_word;
    logic [63:0]            progress_reg;
    logic [63:0]            progress_next;
    logic [63:0]            fail_wide;
    logic [31:0]            core_word;
    logic [31:0]            gen_word;
    logic [1:0]             area_sel;
    logic [31:0]            core_word_reg;
    logic [31:0]            gen_word_reg;
    logic [31:0]            version_reg;
    logic [1:0]             area_sel_reg;
    logic                   req_d1_reg;
    logic [31:0]            rd_data_next;

    assign byte_addr = {REG_ADDR, 2'b00};
    assign area_bits = byte_addr[11:8];

    // ------------------------------------------------------------
    // host status snapshot
    // ------------------------------------------------------------
    always_comb begin
        host_status_next = RST_HOST_STAT;
        host_status_next[HS_LINK_UP]   = LINK_UP;
        host_status_next[HS_CONNECTED] = CONNECTION_STATE;
        host_status_next[HS_CORE_BUSY] = CORE_ACTIVE;
        host_status_next[HS_CORE_ERR]  = CORE_FAULT;
        host_status_next[HS_GEN_BUSY]  = GENERATOR_ACTIVE;
        host_status_next[HS_GEN_FAIL]  = fail_taken;
    end

    // no write path reaches any status storage here
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            host_status_reg <= RST_HOST_STAT;
        end else begin
            host_status_reg <= host_status_next;
        end
    end

    // ------------------------------------------------------------
    // verification capture
    // ------------------------------------------------------------
    assign mismatch  = VERIFY_VALID && (VERIFY_EXPECT != VERIFY_READ);
    assign good_word = VERIFY_VALID && !mismatch;

    // one instance per captured field; all share hit and clear
    shs_capture #(
        .W     (128)
    ) u_expect (
        .CLK   (CLK),
        .SYS_RST (SYS_RST),
        .CLEAR (TEST_START),
        .HIT   (mismatch),
        .DATA  (VERIFY_EXPECT),
        .HELD  (expected_words),
        .TAKEN (fail_taken)
    );

    shs_capture #(
        .W     (128)
    ) u_read (
        .CLK   (CLK),
        .SYS_RST (SYS_RST),
        .CLEAR (TEST_START),
        .HIT   (mismatch),
        .DATA  (VERIFY_READ),
        .HELD  (readback_words),
        .TAKEN ()
    );

    shs_capture #(
        .W     (57)
    ) u_addr (
        .CLK   (CLK),
        .SYS_RST (SYS_RST),
        .CLEAR (TEST_START),
        .HIT   (mismatch),
        .DATA  (VERIFY_ADDR),
        .HELD  (fail_address),
        .TAKEN ()
    );

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            VERIFY_FAULT <= 1'b0;
        end else begin
            VERIFY_FAULT <= fail_taken;
        end
    end

    // ------------------------------------------------------------
    // error-free byte counter
    // ------------------------------------------------------------
    // counting stops at the first mismatch so the total marks
    // how far the data was good
    always_comb begin
        progress_next = progress_reg;
        if (TEST_START) begin
            progress_next = RST_PROGRESS;
        end
        if (good_word && (TEST_START || !fail_taken)) begin
            progress_next = progress_next + BYTES_PER_WORD;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            progress_reg <= RST_PROGRESS;
        end else begin
            progress_reg <= progress_next;
        end
    end

    assign fail_wide = {7'h00, fail_address};

    // ------------------------------------------------------------
    // first mux step: word within the core status area
    // ------------------------------------------------------------
    always_comb begin
        core_word = RST_WORD;
        case (byte_addr[7:0])
            OFF_HOST_STATUS[7:0]: begin
                core_word[HS_W-1:0] = host_status_reg;
            end
            OFF_DISK_LOW[7:0]: begin
                core_word = TARGET_CAPACITY[31:0];
            end
            OFF_DISK_HIGH[7:0]: begin
                core_word[15:0] = TARGET_CAPACITY[47:32];
            end
            OFF_CAP_LOW[7:0]: begin
                core_word = TARGET_CAPABILITY[31:0];
            end
            OFF_CAP_HIGH[7:0]: begin
                core_word[15:0] = TARGET_CAPABILITY[47:32];
            end
            OFF_ERROR_TYPE[7:0]: begin
                core_word = FAULT_VECTOR;
            end
            OFF_COMPLETION[7:0]: begin
                core_word = {IO_COMPLETION, ADMIN_COMPLETION};
            end
            OFF_DEBUG_W0[7:0]: begin
                core_word = DEBUG_PINS[31:0];
            end
            OFF_DEBUG_W1[7:0]: begin
                core_word = DEBUG_PINS[63:32];
            end
            OFF_DEBUG_W2[7:0]: begin
                core_word = DEBUG_PINS[95:64];
            end
            OFF_DEBUG_W3[7:0]: begin
                core_word = DEBUG_PINS[127:96];
            end
            default: begin
                core_word = RST_WORD;
            end
        endcase
    end

    // ------------------------------------------------------------
    // first mux step: word within the generator area
    // ------------------------------------------------------------
    always_comb begin
        gen_word = RST_WORD;
        if (area_bits == AREA_GEN_LO) begin
            case (byte_addr[7:0])
                OFF_EXPECT_W0[7:0]: begin
                    gen_word = expected_words[31:0];
                end
                OFF_EXPECT_W1[7:0]: begin
                    gen_word = expected_words[63:32];
                end
                OFF_EXPECT_W2[7:0]: begin
                    gen_word = expected_words[95:64];
                end
                OFF_EXPECT_W3[7:0]: begin
                    gen_word = expected_words[127:96];
                end
                OFF_READ_W0[7:0]: begin
                    gen_word = readback_words[31:0];
                end
                OFF_READ_W1[7:0]: begin
                    gen_word = readback_words[63:32];
                end
                OFF_READ_W2[7:0]: begin
                    gen_word = readback_words[95:64];
                end
                OFF_READ_W3[7:0]: begin
                    gen_word = readback_words[127:96];
                end
                OFF_FAIL_LOW[7:0]: begin
                    gen_word = fail_wide[31:0];
                end
                OFF_FAIL_HIGH[7:0]: begin
                    gen_word[24:0] = fail_wide[56:32];
                end
                OFF_PROGRESS_LOW[7:0]: begin
                    gen_word = progress_reg[31:0];
                end
                OFF_PROGRESS_HIGH[7:0]: begin
                    gen_word[24:0] = progress_reg[56:32];
                end
                default: begin
                    gen_word = RST_WORD;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // area decode
    // ------------------------------------------------------------
    // below 0x0400 lies the write-only area: reads give zero
    always_comb begin
        area_sel = SEL_NONE;
        if (byte_addr == OFF_VERSION) begin
            area_sel = SEL_VER;
        end else if (byte_addr[15:12] == 4'h0) begin
            if (area_bits == AREA_CORE) begin
                area_sel = SEL_CORE;
            end else if (area_bits >= AREA_GEN_LO &&
                         area_bits <= AREA_GEN_HI) begin
                area_sel = SEL_GEN;
            end
        end
    end

    // ------------------------------------------------------------
    // read pipeline, stage one
    // ------------------------------------------------------------
    // stages run every cycle; the held address keeps them valid
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            core_word_reg <= RST_WORD;
            gen_word_reg  <= RST_WORD;
            version_reg   <= RST_WORD;
            area_sel_reg  <= SEL_NONE;
        end else begin
            core_word_reg <= core_word;
            gen_word_reg  <= gen_word;
            version_reg   <= CORE_VERSION;
            area_sel_reg  <= area_sel;
        end
    end

    // ------------------------------------------------------------
    // read pipeline, stage two
    // ------------------------------------------------------------
    always_comb begin
        case (area_sel_reg)
            SEL_CORE: begin
                rd_data_next = core_word_reg;
            end
            SEL_GEN: begin
                rd_data_next = gen_word_reg;
            end
            SEL_VER: begin
                rd_data_next = version_reg;
            end
            default: begin
                rd_data_next = RST_WORD;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            REG_RD_DATA <= RST_WORD;
        end else begin
            REG_RD_DATA <= rd_data_next;
        end
    end

    // ------------------------------------------------------------
    // read valid, request delayed by two flops
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            req_d1_reg   <= 1'b0;
            REG_RD_VALID <= 1'b0;
        end else begin
            req_d1_reg   <= REG_RD_REQ;
            REG_RD_VALID <= req_d1_reg;
        end
    end

endmodule

// [verification/shs_status_monitor.sv]
// checker of the status bank, sees top ports only
// assumes one clock; inputs are held low while SYS_RST is high
`timescale 1ns/1ns
module shs_status_monitor
    import shs_pkg::*;
(
    input wire logic         CLK,
    input wire logic         SYS_RST,
    input wire logic [13:0]  REG_ADDR,
    input wire logic         REG_RD_REQ,
    input wire logic [31:0]  REG_RD_DATA,
    input wire logic         REG_RD_VALID,
    input wire logic         LINK_UP,
    input wire logic         CONNECTION_STATE,
    input wire logic         CORE_ACTIVE,
    input wire logic         CORE_FAULT,
    input wire logic         GENERATOR_ACTIVE,
    input wire logic [31:0]  FAULT_VECTOR,
    input wire logic [47:0]  TARGET_CAPACITY,
    input wire logic [15:0]  ADMIN_COMPLETION,
    input wire logic [15:0]  IO_COMPLETION,
    input wire logic [31:0]  CORE_VERSION,
    input wire logic         TEST_START,
    input wire logic         VERIFY_VALID,
    input wire logic [127:0] VERIFY_EXPECT,
    input wire logic [127:0] VERIFY_READ,
    input wire logic         VERIFY_FAULT
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    wire [4:0]  st_in = {GENERATOR_ACTIVE, CORE_FAULT, CORE_ACTIVE,
                         CONNECTION_STATE, LINK_UP};
    wire        mism = VERIFY_VALID && (VERIFY_EXPECT != VERIFY_READ);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_read_latency: assert property (
        REG_RD_REQ |-> ##2 REG_RD_VALID)
        else $error("late read valid");
    a_valid_cause: assert property (
        REG_RD_VALID |-> $past(REG_RD_REQ, 2))
        else $error("stray read valid");
    // status word lags one cycle more
    a_status_bits: assert property (
        REG_RD_REQ && REG_ADDR == 14'h100 |-> ##2
        REG_RD_DATA[4:0] == $past(st_in, 3) && REG_RD_DATA[31:6] == '0)
        else $error("bad status word");
    a_size_high: assert property (
        REG_RD_REQ && REG_ADDR == 14'h105 |-> ##2
        REG_RD_DATA == {16'h0000, $past(TARGET_CAPACITY[47:32], 2)})
        else $error("bad size word");
    a_error_vector: assert property (
        REG_RD_REQ && REG_ADDR == 14'h10C |-> ##2
        REG_RD_DATA == $past(FAULT_VECTOR, 2))
        else $error("bad error word");
    a_compl_word: assert property (
        REG_RD_REQ && REG_ADDR == 14'h110 |-> ##2 REG_RD_DATA ==
        {$past(IO_COMPLETION, 2), $past(ADMIN_COMPLETION, 2)})
        else $error("completion word wrong");
    a_version_word: assert property (
        REG_RD_REQ && REG_ADDR == 14'h200 |-> ##2
        REG_RD_DATA == $past(CORE_VERSION, 2))
        else $error("bad version word");
    a_unmapped_zero: assert property (
        REG_RD_REQ && (REG_ADDR == 14'h180 || REG_ADDR == 14'h201)
        |-> ##2 REG_RD_DATA == 32'h0000_0000)
        else $error("gap not zero");
    a_fault_cause: assert property (
        $rose(VERIFY_FAULT) |-> $past(mism, 2))
        else $error("stray fault flag");
    a_fault_sticky: assert property (
        VERIFY_FAULT && !TEST_START && !$past(TEST_START) |=> VERIFY_FAULT)
        else $error("fault flag dropped");
endmodule

bind shs_status_regs shs_status_monitor u_mon (.*);

// [verification/shs_cpu_model.sv]
// cpu side requester: one register read at a time
// assumes the bank answers on CLK
`timescale 1ns/1ns
module shs_cpu_model
    import shs_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        go,
    input  wire logic [13:0] addr,
    input  wire logic        REG_RD_VALID,
    input  wire logic [31:0] REG_RD_DATA,
    output logic      [13:0] REG_ADDR,
    output logic             REG_RD_REQ,
    output logic             busy,
    output logic      [31:0] rd_word
);
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            REG_RD_REQ <= 1'b0;
            busy       <= 1'b0;
            REG_ADDR   <= 14'h0000;
        end else begin
            REG_RD_REQ <= go && !busy;
            if (go && !busy) begin
                REG_ADDR <= addr;
                busy     <= 1'b1;
            end
            // address stays put until valid; then it is scrambled
            if (REG_RD_VALID) begin
                rd_word  <= REG_RD_DATA;
                busy     <= 1'b0;
                REG_ADDR <= ~REG_ADDR;
            end
        end
    end
endmodule

// [verification/test_storage_host_status_regs.sv]
// bench for the host status bank: status bits, fields, verify capture
// assumes the cpu model makes every read request
`timescale 1ns/1ns
module test_storage_host_status_regs
    import shs_pkg::*;
;
    logic         CLK               = 1'b0;
    logic         SYS_RST           = 1'b1;
    logic         LINK_UP           = 1'b0;
    logic         CONNECTION_STATE  = 1'b0;
    logic         CORE_ACTIVE       = 1'b0;
    logic         CORE_FAULT        = 1'b0;
    logic         GENERATOR_ACTIVE  = 1'b0;
    logic         TEST_START        = 1'b0;
    logic         VERIFY_VALID      = 1'b0;
    logic [31:0]  FAULT_VECTOR      = '0;
    logic [31:0]  CORE_VERSION      = '0;
    logic [47:0]  TARGET_CAPACITY   = '0;
    logic [47:0]  TARGET_CAPABILITY = '0;
    logic [15:0]  ADMIN_COMPLETION  = '0;
    logic [15:0]  IO_COMPLETION     = '0;
    logic [127:0] DEBUG_PINS        = '0;
    logic [127:0] VERIFY_EXPECT     = '0;
    logic [127:0] VERIFY_READ       = '0;
    logic [56:0]  VERIFY_ADDR       = '0;
    logic         go                = 1'b0;
    logic [13:0]  addr              = '0;
    logic [13:0]  REG_ADDR;
    logic         REG_RD_REQ;
    logic [31:0]  REG_RD_DATA;
    logic         REG_RD_VALID;
    logic         VERIFY_FAULT;
    logic         busy;
    logic [31:0]  rd_word;
    int           failures          = 0;
    int           n_tests           = 0;
    int           cyc               = 0;

    always #20 CLK = ~CLK;

    shs_status_regs uut (.*);

    shs_cpu_model u_cpu (.*);

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // one read via the cpu model; no answer fails
    task automatic rdc(input string what, input logic [15:0] off,
                       input logic [31:0] exp);
        int i;
        @(posedge CLK);
        go   <= 1'b1;
        addr <= off[15:2];
        @(posedge CLK);
        go <= 1'b0;
        i = 0;
        do begin
            @(posedge CLK);
            #1;
            i++;
        end while (busy !== 1'b0 && i < 8);
        chk(what, exp, busy ? ~exp : rd_word);
    endtask

    task automatic vword(input logic [127:0] e, input logic [127:0] r,
                         input logic [56:0] a);
        @(posedge CLK);
        VERIFY_VALID  <= 1'b1;
        VERIFY_EXPECT <= e;
        VERIFY_READ   <= r;
        VERIFY_ADDR   <= a;
        @(posedge CLK);
        VERIFY_VALID <= 1'b0;
    endtask

    task automatic start_test();
        @(posedge CLK);
        TEST_START <= 1'b1;
        @(posedge CLK);
        TEST_START <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // walking one across the status inputs, then all low
    task automatic t_status();
        logic [4:0] v;
        for (int b = 0; b < 6; b++) begin
            v = (b < 5) ? (5'h01 << b) : 5'h00;
            @(posedge CLK);
            {GENERATOR_ACTIVE, CORE_FAULT, CORE_ACTIVE,
             CONNECTION_STATE, LINK_UP} <= v;
            rdc("host_status", 16'h0400, {27'h0, v});
        end
    endtask

    task automatic t_fields();
        logic [127:0] pins;
        pins = 128'h0F0E0D0C_0B0A0908_07060504_03020100;
        @(posedge CLK);
        TARGET_CAPACITY   <= 48'hA1B2_C3D4_E5F6;
        TARGET_CAPABILITY <= 48'h1357_9BDF_2468;
        FAULT_VECTOR      <= 32'h8000_0001;
        ADMIN_COMPLETION  <= 16'h1234;
        IO_COMPLETION     <= 16'hFEDC;
        DEBUG_PINS        <= pins;
        CORE_VERSION      <= 32'h2468_ACE0;
        rdc("disk_low", 16'h0410, 32'hC3D4_E5F6);
        rdc("disk_high", 16'h0414, 32'h0000_A1B2);
        rdc("cap_low", 16'h0420, 32'h9BDF_2468);
        rdc("cap_high", 16'h0424, 32'h0000_1357);
        rdc("error_type", 16'h0430, 32'h8000_0001);
        rdc("completion", 16'h0440, 32'hFEDC_1234);
        for (int w = 0; w < 4; w++)
            rdc("pins", 16'h0450 + 16'(4 * w), pins[32 * w +: 32]);
        rdc("version", 16'h0800, 32'h2468_ACE0);
        rdc("gap", 16'h0404, 32'h0000_0000);
        rdc("gen_gap", 16'h0600, 32'h0000_0000);
        rdc("ver_gap", 16'h0804, 32'h0000_0000);
        rdc("ctrl_area", 16'h0200, 32'h0000_0000);
    endtask

    // good, good, mismatch, later mismatch, good
    task automatic t_verify();
        logic [127:0] e1, r1, g;
        logic [56:0]  a1;
        e1 = 128'hE3E3E3E3_E2E2E2E2_E1E1E1E1_E0E0E0E0;
        r1 = 128'hD3D3D3D3_D2D2D2D2_D1D1D1D1_D0D0D0D0;
        g  = 128'h5A5A5A5A_A5A5A5A5_3C3C3C3C_C3C3C3C3;
        a1 = 57'h1AB_CDEF_0123_4560;
        start_test();
        vword(g, g, 57'h000);
        vword(g, g, 57'h010);
        vword(e1, r1, a1);
        vword(r1, e1, 57'h040);
        vword(g, g, 57'h050);
        chk("fault_flag", 32'h1, {31'h0, VERIFY_FAULT});
        rdc("host_status", 16'h0400, 32'h0000_0020);
        for (int w = 0; w < 4; w++) begin
            rdc("expect", 16'h0500 + 16'(4 * w), e1[32 * w +: 32]);
            rdc("read", 16'h0540 + 16'(4 * w), r1[32 * w +: 32]);
        end
        rdc("fail_low", 16'h0580, 32'h0123_4560);
        rdc("fail_high", 16'h0584, 32'h01AB_CDEF);
        rdc("progress_low", 16'h0590, 32'h0000_0020);
        rdc("progress_high", 16'h0594, 32'h0000_0000);
        start_test();
        rdc("progress_clear", 16'h0590, 32'h0000_0000);
        rdc("status_clear", 16'h0400, 32'h0000_0000);
        chk("fault_clear", 32'h0, {31'h0, VERIFY_FAULT});
    endtask

    // ------------------------------------------------------------
    // sequence and timeout
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        repeat (16) @(posedge CLK);
        SYS_RST <= 1'b0;
        t_status();
        t_fields();
        t_verify();
        end_sim();
    end
endmodule
